// ### hdl/sfr_dev.sv
// Two-die serial flash: read command engine per die and self-timed write cycle.
`timescale 1ns/1ps
module sfr_dev
    import sfr_pkg::*;
#(
    parameter int MEM_AW = ADDR_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic prog_start_i,
    input wire logic prog_die_i,
    input wire logic [ADDR_W-1:0] prog_addr_i,
    input wire logic [7:0] prog_data_i,
    input wire logic quad_enable_i,
    output wire logic [NUM_DIES-1:0] write_busy_flag_o,
    sfr_link_if.dev link
);

    if (MEM_AW < 1 || MEM_AW > ADDR_W) begin : g_chk
        $error("sfr_dev: MEM_AW must lie between 1 and the address width.");
    end

    if (WRITE_CYCLE_CYC < 1 || WRITE_CYCLE_CYC > 65536) begin : g_chk_tmr
        $error("sfr_dev: the write cycle count must fit the 16-bit timer.");
    end

    for (genvar d = 0; d < NUM_DIES; d++) begin : g_die

        // System-clock side: memory array and self-timed write cycle.
        logic [7:0] mem [0:(2**MEM_AW)-1];
        logic busy_q;
        logic [15:0] tmr_q;
        logic [MEM_AW-1:0] wa_q;
        logic [7:0] wd_q;
        wire start_w = prog_start_i && (prog_die_i == 1'(d)) && !busy_q;
        // The byte lands in the array on the clock on which the flag drops.
        wire done_w = busy_q && (tmr_q == 16'(WRITE_CYCLE_CYC - 1));

        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                busy_q <= 1'b0;
                tmr_q <= 16'h0000;
                wa_q <= '0;
                wd_q <= 8'h00;
            end else if (start_w) begin
                busy_q <= 1'b1;
                tmr_q <= 16'h0000;
                wa_q <= prog_addr_i[MEM_AW-1:0];
                wd_q <= prog_data_i;
            end else if (done_w) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                tmr_q <= tmr_q + 16'h0001;
            end
        end

        always_ff @(posedge clk_sys_i) begin
            if (done_w) begin
                mem[wa_q] <= wd_q;
            end
        end

        // Each die reports its own write cycle.
        assign write_busy_flag_o[d] = busy_q;

        // Link side: the serial clock of the frame; chip select high clears it.
        wire fr_rst = rst_i | link.cs_n[d];
        // The busy flag and the quad enable cross on two serial clock flops each.
        // The serial clock stops between frames, so the opcode clocks refresh them before decode.
        logic [1:0] busy_s_q;
        logic [1:0] qe_s_q;

        always_ff @(posedge link.sclk or posedge rst_i) begin
            if (rst_i) begin
                busy_s_q <= 2'b00;
                qe_s_q <= 2'b00;
            end else begin
                busy_s_q <= {busy_s_q[0], busy_q};
                qe_s_q <= {qe_s_q[0], quad_enable_i};
            end
        end

        sfr_state_t st_q;
        sfr_mode_t md_q;
        logic [4:0] cnt_q;
        logic [23:0] sr_q;
        logic [MEM_AW-1:0] addr_q;

        wire [7:0] op_w = {sr_q[6:0], link.lane[0]};
        sfr_mode_t dec_w;
        assign dec_w = sfr_op2mode(op_w);
        // A refused command only silences the die; the running write cycle is untouched.
        wire busy_rej_w = busy_s_q[1] && (dec_w != SFR_MD_READ);
        wire quad_rej_w = (dec_w == SFR_MD_QUAD_OUT) && !qe_s_q[1];
        wire rej_w = (dec_w == SFR_MD_NONE) || busy_rej_w || quad_rej_w;
        wire opc_end_w = (cnt_q == 5'(OPC_CLKS - 1));
        wire dual_addr_w = (md_q == SFR_MD_DUAL_IO) && (st_q == SFR_ST_ADDR);
        wire [23:0] sr_n_w = dual_addr_w ? {sr_q[21:0], link.lane[1], link.lane[0]}
            : {sr_q[22:0], link.lane[0]};
        wire [4:0] acl_w = sfr_addr_clks(md_q);
        wire [4:0] dum_w = sfr_dummy_clks(md_q);
        wire addr_end_w = (cnt_q == acl_w - 5'h01);
        wire dum_end_w = (cnt_q == dum_w - 5'h01);
        wire no_dummy_w = (dum_w == 5'h00);

        // Command, address and dummy phases are sampled on the rising edge.
        always_ff @(posedge link.sclk or posedge fr_rst) begin
            if (fr_rst) begin
                st_q <= SFR_ST_OPC;
                md_q <= SFR_MD_NONE;
                cnt_q <= 5'h00;
                sr_q <= 24'h000000;
                addr_q <= '0;
            end else begin
                case (st_q)
                    SFR_ST_OPC: begin
                        sr_q <= sr_n_w;
                        cnt_q <= opc_end_w ? 5'h00 : cnt_q + 5'h01;
                        if (opc_end_w) begin
                            md_q <= dec_w;
                            st_q <= rej_w ? SFR_ST_IGNORE : SFR_ST_ADDR;
                        end
                    end
                    SFR_ST_ADDR: begin
                        sr_q <= sr_n_w;
                        cnt_q <= addr_end_w ? 5'h00 : cnt_q + 5'h01;
                        if (addr_end_w) begin
                            addr_q <= sr_n_w[MEM_AW-1:0];
                            st_q <= no_dummy_w ? SFR_ST_DATA : SFR_ST_DUMMY;
                        end
                    end
                    SFR_ST_DUMMY: begin
                        // Dummy clocks carry no data; the host leaves the lanes released.
                        cnt_q <= cnt_q + 5'h01;
                        if (dum_end_w) begin
                            st_q <= SFR_ST_DATA;
                        end
                    end
                    default: begin
                        st_q <= st_q;
                    end
                endcase
            end
        end

        // Data output: one slice per falling edge, next byte fetched at the slice wrap.
        logic started_q;
        logic [2:0] sl_q;
        logic [MEM_AW-1:0] ptr_q;
        logic [3:0] dat_q;
        logic [3:0] oe_n_q;

        wire [2:0] ln_w = sfr_lanes(md_q);
        wire is_quad_w = (ln_w == 3'h4);
        wire is_dual_w = (ln_w == 3'h2);
        wire [2:0] sl_last_w = sfr_last_slice(ln_w);
        wire data_ph_w = (st_q == SFR_ST_DATA);
        wire [2:0] sl_e_w = started_q ? sl_q : 3'h0;
        wire [MEM_AW-1:0] ptr_w = !started_q ? addr_q
            : (sl_q == 3'h0) ? ptr_q + 1'b1 : ptr_q;
        // The array is read across domains; a byte still under write may return either value.
        wire [7:0] byte_w = mem[ptr_w];
        wire [5:0] shamt_w = {3'h0, sl_e_w} * {3'h0, ln_w};
        wire [7:0] sh_w = byte_w << shamt_w;
        wire [3:0] quad_out_w = sh_w[7:4];
        wire [3:0] dual_out_w = {2'b00, sh_w[7:6]};
        wire [3:0] single_out_w = {2'b00, sh_w[7], 1'b0};
        wire [3:0] out_w = is_quad_w ? quad_out_w : is_dual_w ? dual_out_w : single_out_w;
        wire [3:0] oe_w = is_quad_w ? 4'h0 : is_dual_w ? 4'hC : 4'hD;

        // Deselect releases the lanes at once, without waiting for a clock edge.
        always_ff @(negedge link.sclk or posedge fr_rst) begin
            if (fr_rst) begin
                started_q <= 1'b0;
                sl_q <= 3'h0;
                ptr_q <= '0;
                dat_q <= 4'h0;
                oe_n_q <= 4'hF;
            end else if (data_ph_w) begin
                started_q <= 1'b1;
                ptr_q <= ptr_w;
                sl_q <= (sl_e_w == sl_last_w) ? 3'h0 : sl_e_w + 3'h1;
                dat_q <= out_w;
                oe_n_q <= oe_w;
            end else begin
                oe_n_q <= 4'hF;
            end
        end

        assign link.dev_dat[d] = dat_q;
        assign link.dev_oe_n[d] = oe_n_q;
    end

endmodule : sfr_dev

// ### include/sfr_pkg.sv
// Shared constants, types and decode functions of the serial flash read link.
package sfr_pkg;

    localparam int ADDR_W = 24;
    localparam int NUM_DIES = 2;
    localparam int LANES = 4;
    localparam int OPC_CLKS = 8;
    localparam logic [4:0] ADDR_CLKS_SINGLE = 5'h18;
    localparam logic [4:0] ADDR_CLKS_DUAL = 5'h0C;
    localparam logic [4:0] DUMMY_FAST = 5'h08;
    localparam logic [4:0] DUMMY_DUAL_OUT = 5'h08;
    localparam logic [4:0] DUMMY_DUAL_IO = 5'h04;
    localparam logic [4:0] DUMMY_QUAD_OUT = 5'h08;

    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6B;

    localparam int SYS_PERIOD_NS = 10;
    localparam int WRITE_CYCLE_NS = 1000;
    localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int HOST_HALF_DEF = 4;

    typedef enum logic [2:0] {
        SFR_MD_READ,
        SFR_MD_FAST,
        SFR_MD_DUAL_OUT,
        SFR_MD_DUAL_IO,
        SFR_MD_QUAD_OUT,
        SFR_MD_NONE
    } sfr_mode_t;

    typedef enum logic [2:0] {
        SFR_ST_IDLE,
        SFR_ST_OPC,
        SFR_ST_ADDR,
        SFR_ST_DUMMY,
        SFR_ST_DATA,
        SFR_ST_IGNORE
    } sfr_state_t;

    function automatic sfr_mode_t sfr_op2mode(input logic [7:0] op);
        case (op)
            OP_READ: return SFR_MD_READ;
            OP_FAST: return SFR_MD_FAST;
            OP_DUAL_OUT: return SFR_MD_DUAL_OUT;
            OP_DUAL_IO: return SFR_MD_DUAL_IO;
            OP_QUAD_OUT: return SFR_MD_QUAD_OUT;
            default: return SFR_MD_NONE;
        endcase
    endfunction : sfr_op2mode

    function automatic logic [7:0] sfr_mode2op(input sfr_mode_t m);
        case (m)
            SFR_MD_FAST: return OP_FAST;
            SFR_MD_DUAL_OUT: return OP_DUAL_OUT;
            SFR_MD_DUAL_IO: return OP_DUAL_IO;
            SFR_MD_QUAD_OUT: return OP_QUAD_OUT;
            default: return OP_READ;
        endcase
    endfunction : sfr_mode2op

    function automatic logic [4:0] sfr_addr_clks(input sfr_mode_t m);
        return (m == SFR_MD_DUAL_IO) ? ADDR_CLKS_DUAL : ADDR_CLKS_SINGLE;
    endfunction : sfr_addr_clks

    function automatic logic [4:0] sfr_dummy_clks(input sfr_mode_t m);
        case (m)
            SFR_MD_FAST: return DUMMY_FAST;
            SFR_MD_DUAL_OUT: return DUMMY_DUAL_OUT;
            SFR_MD_DUAL_IO: return DUMMY_DUAL_IO;
            SFR_MD_QUAD_OUT: return DUMMY_QUAD_OUT;
            default: return 5'h00;
        endcase
    endfunction : sfr_dummy_clks

    function automatic logic [2:0] sfr_lanes(input sfr_mode_t m);
        case (m)
            SFR_MD_DUAL_OUT, SFR_MD_DUAL_IO: return 3'h2;
            SFR_MD_QUAD_OUT: return 3'h4;
            default: return 3'h1;
        endcase
    endfunction : sfr_lanes

    function automatic logic [2:0] sfr_last_slice(input logic [2:0] n);
        case (n)
            3'h4: return 3'h1;
            3'h2: return 3'h3;
            default: return 3'h7;
        endcase
    endfunction : sfr_last_slice

endpackage : sfr_pkg

// ### include/sfr_link_if.sv
// Serial flash link between the host controller and the two-die flash.
`timescale 1ns/1ps
interface sfr_link_if;
    logic sclk;
    logic [1:0] cs_n;
    logic [3:0] host_dat;
    logic [3:0] host_oe_n;
    wire [1:0][3:0] dev_dat;
    wire [1:0][3:0] dev_oe_n;
    wire [3:0] lane;

    // Wire level of each lane; an undriven lane is pulled high.
    assign lane = (~host_oe_n & host_dat) | (~dev_oe_n[0] & dev_dat[0]) | (~dev_oe_n[1] & dev_dat[1])
        | (host_oe_n & dev_oe_n[0] & dev_oe_n[1]);

    modport host (output sclk, output cs_n, output host_dat, output host_oe_n, input lane);
    modport dev (input sclk, input cs_n, input lane, output dev_dat, output dev_oe_n);
endinterface : sfr_link_if

// ### hdl/sfr_host.sv
// Host controller: issues one read command and streams the bytes back.
`timescale 1ns/1ps
module sfr_host
    import sfr_pkg::*;
#(
    parameter int HALF = HOST_HALF_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input sfr_mode_t cmd_mode_i,
    input wire logic cmd_die_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic [15:0] cmd_len_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    sfr_link_if.host link
);

    if (HALF < 3 || HALF > 255) begin : g_chk
        $error("sfr_host: HALF must lie between 3 and 255.");
    end

    sfr_state_t st_q;
    sfr_mode_t md_q;
    logic [7:0] hc_q;
    logic sclk_q;
    logic [1:0] cs_n_q;
    logic [31:0] tx_q;
    logic [5:0] rc_q;
    logic [5:0] pre_q;
    logic [5:0] cmd_end_q;
    logic [7:0] rx_q;
    logic [2:0] sl_q;
    logic [15:0] left_q;
    logic done_q;
    logic [3:0] dat_q;
    logic [3:0] oe_n_q;
    logic [3:0] s1_q;
    logic [3:0] s2_q;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
        end else begin
            s1_q <= link.lane;
            s2_q <= s1_q;
        end
    end

    wire tick_w = (hc_q == 8'(HALF - 1));
    wire rise_w = (st_q != SFR_ST_IDLE) && tick_w && !sclk_q;
    wire fall_w = (st_q != SFR_ST_IDLE) && tick_w && sclk_q;
    wire [7:0] op_w = sfr_mode2op(cmd_mode_i);
    wire [5:0] acl_w = {1'b0, sfr_addr_clks(cmd_mode_i)};
    wire [5:0] dum_w = {1'b0, sfr_dummy_clks(cmd_mode_i)};
    wire two_w = (md_q == SFR_MD_DUAL_IO) && (rc_q > 6'(OPC_CLKS));
    wire [31:0] tx_n_w = two_w ? {tx_q[29:0], 2'b00} : {tx_q[30:0], 1'b0};
    wire [2:0] ln_w = sfr_lanes(md_q);
    wire [2:0] sl_last_w = sfr_last_slice(ln_w);
    wire [7:0] rx_n_w = (ln_w == 3'h4) ? {rx_q[3:0], s2_q[3:0]}
        : (ln_w == 3'h2) ? {rx_q[5:0], s2_q[1:0]} : {rx_q[6:0], s2_q[1]};
    wire samp_w = rise_w && (rc_q >= pre_q);
    wire byte_w = samp_w && (sl_q == sl_last_w);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= SFR_ST_IDLE;
            md_q <= SFR_MD_READ;
            hc_q <= 8'h00;
            sclk_q <= 1'b0;
            cs_n_q <= 2'b11;
            tx_q <= 32'h00000000;
            rc_q <= 6'h00;
            pre_q <= 6'h00;
            cmd_end_q <= 6'h00;
            rx_q <= 8'h00;
            sl_q <= 3'h0;
            left_q <= 16'h0000;
            done_q <= 1'b0;
            dat_q <= 4'h0;
            oe_n_q <= 4'hF;
            cmd_ready_o <= 1'b1;
            rd_valid_o <= 1'b0;
            rd_data_o <= 8'h00;
        end else begin
            rd_valid_o <= byte_w;
            hc_q <= (st_q == SFR_ST_IDLE || tick_w) ? 8'h00 : hc_q + 8'h01;
            if (st_q == SFR_ST_IDLE && cmd_valid_i) begin
                st_q <= SFR_ST_OPC;
                md_q <= cmd_mode_i;
                cs_n_q <= cmd_die_i ? 2'b01 : 2'b10;
                tx_q <= {op_w, cmd_addr_i};
                dat_q <= {3'h0, op_w[7]};
                oe_n_q <= 4'hE;
                rc_q <= 6'h00;
                cmd_end_q <= 6'(OPC_CLKS) + acl_w;
                pre_q <= 6'(OPC_CLKS) + acl_w + dum_w;
                sl_q <= 3'h0;
                left_q <= cmd_len_i;
                done_q <= 1'b0;
                cmd_ready_o <= 1'b0;
            end
            if (rise_w) begin
                sclk_q <= 1'b1;
                rc_q <= (rc_q == 6'h3F) ? rc_q : rc_q + 6'h01;
            end
            if (samp_w) begin
                rx_q <= rx_n_w;
                sl_q <= (sl_q == sl_last_w) ? 3'h0 : sl_q + 3'h1;
            end
            if (byte_w) begin
                rd_data_o <= rx_n_w;
                left_q <= left_q - 16'h0001;
                done_q <= (left_q <= 16'h0001);
            end
            if (fall_w) begin
                sclk_q <= 1'b0;
                if (done_q) begin
                    cs_n_q <= 2'b11;
                    oe_n_q <= 4'hF;
                    st_q <= SFR_ST_IDLE;
                    cmd_ready_o <= 1'b1;
                end else if (rc_q < cmd_end_q) begin
                    tx_q <= tx_n_w;
                    dat_q <= two_w || (md_q == SFR_MD_DUAL_IO && rc_q == 6'(OPC_CLKS))
                        ? {2'b00, tx_n_w[31:30]} : {3'h0, tx_n_w[31]};
                    oe_n_q <= (md_q == SFR_MD_DUAL_IO && rc_q >= 6'(OPC_CLKS)) ? 4'hC : 4'hE;
                end else begin
                    oe_n_q <= 4'hF;
                end
            end
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.host_dat = dat_q;
    assign link.host_oe_n = oe_n_q;

endmodule : sfr_host

// ### verification/sfr_link_props.sv
// Concurrent checks on the link between the host controller and the two-die flash.
`timescale 1ns/1ps
module sfr_link_props
    import sfr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic [1:0] cs_n,
    input wire logic [3:0] host_oe_n,
    input wire [1:0][3:0] dev_dat,
    input wire [1:0][3:0] dev_oe_n,
    input wire logic [1:0] write_busy_flag_i
);
    logic sclk_q;
    logic [5:0] rise_q;
    logic [7:0] busy_q;
    wire logic rise_w = sclk & ~sclk_q & ~(&rise_q);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            rise_q <= 6'h00;
            busy_q <= 8'h00;
        end else begin
            sclk_q <= sclk;
            rise_q <= (&cs_n) ? 6'h00 : rise_q + {5'h00, rise_w};
            busy_q <= write_busy_flag_i[0] ? busy_q + 8'h01 : 8'h00;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    release_die0_a: assert property (cs_n[0] && $past(cs_n[0]) |-> dev_oe_n[0] == 4'hF)
        else $error("die 0 drives while deselected");
    release_die1_a: assert property (cs_n[1] && $past(cs_n[1]) |-> dev_oe_n[1] == 4'hF)
        else $error("die 1 drives while deselected");
    single_select_a: assert property (cs_n != 2'b00)
        else $error("both dies selected");
    one_die_a: assert property (!((dev_oe_n[0] != 4'hF) && (dev_oe_n[1] != 4'hF)))
        else $error("both dies drive the lanes");
    no_contention_a: assert property ((~host_oe_n & ~(dev_oe_n[0] & dev_oe_n[1])) == 4'h0)
        else $error("host and device drive one lane");
    preamble_quiet_a: assert property (rise_q < 6'h18 |-> dev_oe_n == 8'hFF)
        else $error("device drives before the data phase");
    shift_fall_a: assert property (!cs_n[0] && $past(!cs_n[0]) && $changed(~dev_oe_n[0] & dev_dat[0])
        |-> $fell(sclk))
        else $error("data changed away from a falling clock");
    busy_len_a: assert property ($fell(write_busy_flag_i[0]) |-> busy_q == 8'(WRITE_CYCLE_CYC))
        else $error("write cycle length wrong");
endmodule : sfr_link_props

// ### verification/tb.sv
// Self-checking bench joining the host controller and the two-die flash.
`timescale 1ns/1ps
module tb;
    import sfr_pkg::*;
    localparam int LIMIT = 40000;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic prog_start = 1'b0;
    logic prog_die = 1'b0;
    logic [5:0] prog_addr = 6'h00;
    logic [7:0] prog_data = 8'h00;
    logic quad_en = 1'b1;
    logic cmd_valid = 1'b0;
    sfr_mode_t cmd_mode = SFR_MD_READ;
    logic cmd_die = 1'b0;
    logic [5:0] cmd_addr = 6'h00;
    logic [15:0] cmd_len = 16'h0001;
    logic cmd_ready;
    logic rd_valid;
    logic [7:0] rd_data;
    logic [1:0] busy;
    logic [31:0] wire_q = 32'h0;
    logic [31:0] wire_cap = 32'h0;
    int bits = 0;
    int cyc = 0;
    int err_total = 0;
    int n_compared = 0;
    sfr_mode_t modes[5] = '{SFR_MD_READ, SFR_MD_FAST, SFR_MD_DUAL_OUT, SFR_MD_DUAL_IO, SFR_MD_QUAD_OUT};
    logic [7:0] ops[5] = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT};

    sfr_link_if link ();
    sfr_dev #(.MEM_AW(6)) sfr_dev_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .prog_start_i(prog_start),
        .prog_die_i(prog_die), .prog_addr_i({18'h00000, prog_addr}), .prog_data_i(prog_data),
        .quad_enable_i(quad_en), .write_busy_flag_o(busy), .link(link));
    sfr_host #(.HALF(4)) sfr_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_mode_i(cmd_mode), .cmd_die_i(cmd_die), .cmd_addr_i({18'h00000, cmd_addr}),
        .cmd_len_i(cmd_len), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .link(link));
    sfr_link_props sfr_link_props_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk(link.sclk), .cs_n(link.cs_n),
        .host_oe_n(link.host_oe_n), .dev_dat(link.dev_dat), .dev_oe_n(link.dev_oe_n), .write_busy_flag_i(busy));

    always #5 clk_sys_i = ~clk_sys_i;

    always @(posedge link.sclk) begin
        if (link.cs_n != 2'b11) begin
            wire_q = {wire_q[30:0], link.lane[0]};
            bits++;
            if (bits == 32) wire_cap = wire_q;
        end
    end

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            finish_test();
        end
    end

    function automatic logic [7:0] pat(input logic d, input logic [5:0] a);
        return {a, d, ~d} ^ 8'h3C;
    endfunction : pat

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic prog_go(input logic d, input logic [5:0] a);
        @(posedge clk_sys_i);
        #1;
        prog_die = d;
        prog_addr = a;
        prog_data = pat(d, a);
        prog_start = 1'b1;
        @(posedge clk_sys_i);
        #1;
        prog_start = 1'b0;
        check(busy[d], 1'b1);
    endtask : prog_go

    task automatic prog_wait(input logic d);
        for (int n = 0; n < 300 && busy[d] !== 1'b0; n++) begin
            @(posedge clk_sys_i);
            #1;
        end
        check(busy[d], 1'b0);
    endtask : prog_wait

    task automatic rd(input int i, input logic d, input logic [5:0] a, input int len, input logic rej);
        int n;
        int k;
        n = 0;
        k = 0;
        while (cmd_ready !== 1'b1 && n < 9000) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        cmd_mode = modes[i];
        cmd_die = d;
        cmd_addr = a;
        cmd_len = 16'(len);
        cmd_valid = 1'b1;
        bits = 0;
        @(posedge clk_sys_i);
        #1;
        cmd_valid = 1'b0;
        check(cmd_ready, 1'b0);
        while (k < len && n < 20000) begin
            @(posedge clk_sys_i);
            #1;
            n++;
            if (rd_valid === 1'b1) begin
                check(rd_data, rej ? 8'hFF : pat(d, a + 6'(k)));
                k++;
            end
        end
        check(k, len);
        check(wire_cap[31:24], ops[i]);
        if (i != 3) check(wire_cap[23:0], {18'h00000, a});
    endtask : rd

    initial begin
        repeat (16) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        for (int j = 0; j < 16; j++) begin
            prog_go(j[3], 6'(60 + j % 8));
            prog_wait(j[3]);
        end
        $display("test load done");
        for (int j = 0; j < 10; j++) rd(j % 5, j >= 5, 6'h3E, 2 + j % 5, 1'b0);
        $display("test modes done");
        quad_en = 1'b0;
        rd(4, 1'b0, 6'h3E, 2, 1'b1);
        quad_en = 1'b1;
        $display("test quad enable done");
        for (int j = 1; j < 5; j++) begin
            prog_go(1'b0, 6'h3C);
            rd(j, 1'b0, 6'h3E, 2, 1'b1);
            prog_wait(1'b0);
        end
        rd(1, 1'b0, 6'h3C, 1, 1'b0);
        prog_go(1'b0, 6'h3D);
        rd(1, 1'b1, 6'h3E, 1, 1'b0);
        prog_wait(1'b0);
        prog_go(1'b0, 6'h3D);
        rd(0, 1'b0, 6'h3E, 1, 1'b0);
        prog_wait(1'b0);
        $display("test busy done");
        finish_test();
    end
endmodule : tb
